// [hw/frp_pkg.sv]
// Constants for the flash row program and protect sequencer.
package frp_pkg;
  // Register word offsets on the bus.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_BOUND = 8'h04;
  localparam logic [7:0] OFF_ARRAY = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0C;
  // Control register bit positions.
  localparam int PGM_BIT = 0;
  localparam int ERS_BIT = 1;
  localparam int MASS_BIT = 2;
  localparam int HV_BIT = 3;
  // Array window write layout: address low half, byte above it.
  localparam int AW_ADDR_LSB = 0;
  localparam int AW_DATA_LSB = 16;
  // Status register bit positions.
  localparam int ST_SEQERR_BIT = 0;
  localparam int ST_PROTRD_BIT = 1;
  localparam int ST_ROWPROT_BIT = 2;
  localparam int ST_TESTHV_BIT = 3;
  localparam int ST_ARMED_BIT = 4;
  localparam int ST_ROW_LSB = 16;
  // Array geometry and special locations.
  localparam int ROW_LSB = 5;
  localparam int PAGE_LSB = 6;
  localparam logic [1:0] PROT_TOP_BITS = 2'h3;
  localparam logic [15:0] BOUND_ADDR = 16'hFF7E;
  localparam logic [7:0] BOUND_OPEN = 8'hFF;
  localparam logic [7:0] BOUND_VECT = 8'hFE;
  localparam logic [7:0] BOUND_ALL = 8'h00;
  localparam logic [7:0] BOUND_RESET = 8'hFF;
  // Sequencer states.
  typedef enum logic [1:0] {
    FRP_IDLE, FRP_SELECTED, FRP_ARMED, FRP_HV
  } frp_state_t;
endpackage : frp_pkg

// [hw/frp_seq.sv]
// Flash row program sequencer with block protection and bus registers.
//
// Implementation choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module frp_seq #(
  parameter logic [7:0] BOUND_INIT = frp_pkg::BOUND_RESET
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Wishbone classic slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Low power request and test voltage pin.
  input wire logic low_power_i,
  input wire logic test_high_voltage_i,
  // Array control.
  output logic pump_on_o,
  output logic array_hv_o,
  output logic prog_mode_o,
  output logic erase_mode_o,
  output logic mass_mode_o,
  output logic array_we_o,
  output logic [15:0] array_addr_o,
  output logic [7:0] array_data_o
);
  logic rst_n_meta_q, rst_n_q, thv_s1_q, thv_s2_q, thv_s3_q, thv_q;
  logic ack_q, pgm_q, ers_q, mass_q, hv_q, prot_rd_q, seq_err_q, we_q;
  logic [31:0] rdat_q;
  logic [7:0] bpr_q, wdata_q, aw_data;
  logic [15:0] row_q, waddr_q, aw_addr, prot_start;
  frp_pkg::frp_state_t st_q;
  logic acc, wr, rd, wr_ctrl, wr_arr, rd_bound, row_prot, byte_prot;
  logic mass_blk, pgm_d, ers_d, hv_req, hv_ok, hv_rise, byte_go;

  // Reset is asserted at once and released through two flops.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_n_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_n_meta_q <= 1'b1;
      rst_n_q <= rst_n_meta_q;
    end
  end

  // The test voltage pin passes three flops; agreement of two counts.
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      thv_s1_q <= 1'b0;
      thv_s2_q <= 1'b0;
      thv_s3_q <= 1'b0;
      thv_q <= 1'b0;
    end else begin
      thv_s1_q <= test_high_voltage_i;
      thv_s2_q <= thv_s1_q;
      thv_s3_q <= thv_s2_q;
      if (thv_s2_q == thv_s3_q) begin
        thv_q <= thv_s3_q;
      end
    end
  end

  // Bus decode; one access per request, answered one cycle later.
  assign acc = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr = acc & wb_we_i;
  assign rd = acc & ~wb_we_i;
  assign wr_ctrl = wr & (wb_adr_i == frp_pkg::OFF_CTRL) & wb_sel_i[0];
  assign wr_arr = wr & (wb_adr_i == frp_pkg::OFF_ARRAY) & (&wb_sel_i[2:0]);
  assign rd_bound = rd & (wb_adr_i == frp_pkg::OFF_BOUND);
  assign aw_addr = wb_dat_i[frp_pkg::AW_ADDR_LSB +: 16];
  assign aw_data = wb_dat_i[frp_pkg::AW_DATA_LSB +: 8];

  // Protected range starts at the boundary page and runs to the top.
  assign prot_start = {frp_pkg::PROT_TOP_BITS, bpr_q, 6'h00};
  assign row_prot = ~thv_q & (bpr_q != frp_pkg::BOUND_OPEN)
    & (row_q >= prot_start);
  assign byte_prot = ~thv_q & (bpr_q != frp_pkg::BOUND_OPEN)
    & (aw_addr >= prot_start);
  assign mass_blk = ~thv_q & (bpr_q != frp_pkg::BOUND_OPEN);

  // Selects after a control write; both at once keeps the old pair.
  always_comb begin
    pgm_d = pgm_q;
    ers_d = ers_q;
    if (wr_ctrl && !(wb_dat_i[frp_pkg::PGM_BIT]
        && wb_dat_i[frp_pkg::ERS_BIT])) begin
      pgm_d = wb_dat_i[frp_pkg::PGM_BIT];
      ers_d = wb_dat_i[frp_pkg::ERS_BIT];
    end
  end

  // High voltage needs an armed, read, open row; mass is the written bit.
  assign hv_req = wr_ctrl & wb_dat_i[frp_pkg::HV_BIT] & ~hv_q;
  assign hv_ok = (pgm_d ^ ers_d) & prot_rd_q & (st_q == frp_pkg::FRP_ARMED)
    & ~((ers_d & wb_dat_i[frp_pkg::MASS_BIT])
    ? mass_blk : row_prot);
  assign hv_rise = hv_req & hv_ok & ~low_power_i;
  assign byte_go = wr_arr & pgm_q & hv_q & ~byte_prot
    & (aw_addr[15:frp_pkg::ROW_LSB] == row_q[15:frp_pkg::ROW_LSB]);

  // Control bits; wait or stop drops everything into standby.
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pgm_q <= 1'b0;
      ers_q <= 1'b0;
      mass_q <= 1'b0;
      hv_q <= 1'b0;
    end else if (low_power_i) begin
      pgm_q <= 1'b0;
      ers_q <= 1'b0;
      mass_q <= 1'b0;
      hv_q <= 1'b0;
    end else if (wr_ctrl) begin
      pgm_q <= pgm_d;
      ers_q <= ers_d;
      mass_q <= wb_dat_i[frp_pkg::MASS_BIT];
      hv_q <= wb_dat_i[frp_pkg::HV_BIT] & (hv_q | hv_ok);
    end
  end

  // Sequence state: select, row latched, high voltage applied.
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q <= frp_pkg::FRP_IDLE;
    end else if (low_power_i) begin
      st_q <= frp_pkg::FRP_IDLE;
    end else begin
      case (st_q)
        frp_pkg::FRP_IDLE: begin
          if (pgm_d | ers_d) begin
            st_q <= frp_pkg::FRP_SELECTED;
          end
        end
        frp_pkg::FRP_SELECTED: begin
          if (!(pgm_d | ers_d)) begin
            st_q <= frp_pkg::FRP_IDLE;
          end else if (wr_arr) begin
            st_q <= frp_pkg::FRP_ARMED;
          end
        end
        frp_pkg::FRP_ARMED: begin
          if (hv_rise) begin
            st_q <= frp_pkg::FRP_HV;
          end else if (!(pgm_d | ers_d)) begin
            st_q <= frp_pkg::FRP_IDLE;
          end
        end
        frp_pkg::FRP_HV: begin
          if (wr_ctrl && !wb_dat_i[frp_pkg::HV_BIT]) begin
            st_q <= (pgm_d | ers_d) ? frp_pkg::FRP_SELECTED
              : frp_pkg::FRP_IDLE;
          end
        end
        default: begin
          st_q <= frp_pkg::FRP_IDLE;
        end
      endcase
    end
  end

  // Row address is latched by the first array write after select.
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      row_q <= 16'h0000;
    end else if (wr_arr && st_q == frp_pkg::FRP_SELECTED) begin
      row_q <= aw_addr;
    end
  end

  // Boundary read flag; a fresh select clears it, the read sets it.
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      prot_rd_q <= 1'b0;
    end else if (rd_bound && (pgm_q | ers_q)) begin
      prot_rd_q <= 1'b1;
    end else if (low_power_i || !(pgm_d | ers_d)
        || (pgm_d & ~pgm_q) || (ers_d & ~ers_q)) begin
      prot_rd_q <= 1'b0;
    end
  end

  // Sticky sequence error; writing one to its status bit clears it.
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      seq_err_q <= 1'b0;
    end else if (hv_req && !prot_rd_q) begin
      seq_err_q <= 1'b1;
    end else if (wr && wb_adr_i == frp_pkg::OFF_STAT && wb_sel_i[0]
        && wb_dat_i[frp_pkg::ST_SEQERR_BIT]) begin
      seq_err_q <= 1'b0;
    end
  end

  // Boundary byte lives in the array: only program or erase alter it.
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      bpr_q <= BOUND_INIT;
    end else if (hv_rise && ers_d && (wb_dat_i[frp_pkg::MASS_BIT]
        || row_q[15:frp_pkg::PAGE_LSB]
        == frp_pkg::BOUND_ADDR[15:frp_pkg::PAGE_LSB])) begin
      bpr_q <= frp_pkg::BOUND_RESET;
    end else if (byte_go && aw_addr == frp_pkg::BOUND_ADDR) begin
      bpr_q <= bpr_q & aw_data;
    end
  end

  // Byte program strobe with the latched address and data.
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      we_q <= 1'b0;
      waddr_q <= 16'h0000;
      wdata_q <= 8'h00;
    end else begin
      we_q <= byte_go & ~low_power_i;
      if (byte_go) begin
        waddr_q <= aw_addr;
        wdata_q <= aw_data;
      end
    end
  end

  // Read data and acknowledge; unmapped offsets read zero.
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= acc;
      rdat_q <= 32'h0000_0000;
      if (rd) begin
        case (wb_adr_i)
          frp_pkg::OFF_CTRL: begin
            rdat_q[frp_pkg::PGM_BIT] <= pgm_q;
            rdat_q[frp_pkg::ERS_BIT] <= ers_q;
            rdat_q[frp_pkg::MASS_BIT] <= mass_q;
            rdat_q[frp_pkg::HV_BIT] <= hv_q;
          end
          frp_pkg::OFF_BOUND: begin
            rdat_q[7:0] <= bpr_q;
          end
          frp_pkg::OFF_STAT: begin
            rdat_q[frp_pkg::ST_SEQERR_BIT] <= seq_err_q;
            rdat_q[frp_pkg::ST_PROTRD_BIT] <= prot_rd_q;
            rdat_q[frp_pkg::ST_ROWPROT_BIT] <= row_prot;
            rdat_q[frp_pkg::ST_TESTHV_BIT] <= thv_q;
            rdat_q[frp_pkg::ST_ARMED_BIT] <= (st_q == frp_pkg::FRP_ARMED);
            rdat_q[frp_pkg::ST_ROW_LSB +: 16] <= row_q;
          end
          default: begin
            rdat_q <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // Outputs come straight from the flops above.
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign pump_on_o = hv_q;
  assign array_hv_o = hv_q;
  assign prog_mode_o = pgm_q;
  assign erase_mode_o = ers_q;
  assign mass_mode_o = mass_q;
  assign array_we_o = we_q;
  assign array_addr_o = waddr_q;
  assign array_data_o = wdata_q;

  // Checks on the sequencer behaviour.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n_q);
  property p_hv_open;
    $rose(hv_q) |-> $past(!row_prot || (ers_q && mass_q));
  endproperty
  a_hv_open: assert property (p_hv_open)
    else $error("High voltage rose on a protected row.");
  property p_hv_read;
    $rose(hv_q) |-> $past(prot_rd_q);
  endproperty
  a_hv_read: assert property (p_hv_read)
    else $error("High voltage rose without a boundary read.");
  property p_mass;
    $rose(hv_q) && ers_q && mass_q |-> $past(!mass_blk);
  endproperty
  a_mass: assert property (p_mass)
    else $error("Mass erase ran with a protected block.");
  property p_mass_clear;
    $rose(hv_q) && ers_q && mass_q |-> bpr_q == frp_pkg::BOUND_RESET;
  endproperty
  a_mass_clear: assert property (p_mass_clear)
    else $error("Mass erase left the boundary byte set.");
  property p_interlock;
    !(pgm_q && ers_q);
  endproperty
  a_interlock: assert property (p_interlock)
    else $error("Program and erase selected together.");
  property p_standby;
    low_power_i |=> !hv_q && !pgm_q && !ers_q && !array_we_o;
  endproperty
  a_standby: assert property (p_standby)
    else $error("Low power did not drop the array to standby.");
  property p_bound_change;
    $changed(bpr_q) |-> $past(hv_rise || byte_go);
  endproperty
  a_bound_change: assert property (p_bound_change)
    else $error("Boundary byte changed outside a sequence.");
  property p_byte_range;
    array_we_o |-> $past(thv_q) || $past(bpr_q) == frp_pkg::BOUND_OPEN
      || array_addr_o < $past(prot_start);
  endproperty
  a_byte_range: assert property (p_byte_range)
    else $error("Byte programmed inside the protected range.");
  property p_byte_row;
    array_we_o |-> $past(pgm_q && hv_q)
      && array_addr_o[15:5] == row_q[15:5];
  endproperty
  a_byte_row: assert property (p_byte_row)
    else $error("Byte programmed outside the latched row.");
  property p_all_prot;
    $rose(hv_q) && pgm_q |-> $past(bpr_q) != frp_pkg::BOUND_ALL
      || $past(thv_q);
  endproperty
  a_all_prot: assert property (p_all_prot)
    else $error("Program started with the whole array protected.");
  property p_bound_lock;
    array_we_o && array_addr_o == frp_pkg::BOUND_ADDR
      |-> $past(thv_q) || $past(bpr_q) == frp_pkg::BOUND_OPEN
      || $past(bpr_q) == frp_pkg::BOUND_VECT;
  endproperty
  a_bound_lock: assert property (p_bound_lock)
    else $error("Locked boundary byte was programmed.");
  c_program: cover property ($rose(hv_q) && pgm_q ##[1:200] array_we_o);
  c_refused: cover property (hv_req && prot_rd_q && !hv_ok);
  c_seq_err: cover property ($rose(seq_err_q));
  c_abort: cover property (hv_q && low_power_i);
endmodule : frp_seq
`default_nettype wire

// [test/frp_tb.sv]
// Self-checking bench for the flash row program and protect sequencer.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic low_power_i = 1'b0, test_high_voltage_i = 1'b0;
  logic [31:0] wb_dat_o, rd;
  logic wb_ack_o, pump_on_o, array_hv_o, prog_mode_o, erase_mode_o;
  logic mass_mode_o, array_we_o;
  logic [15:0] array_addr_o, we_addr, a;
  logic [7:0] array_data_o, we_data, bnd;
  logic [3:0] sel_v = 4'hF;
  int err_total = 0;
  int tests_run = 0;
  int we_cnt = 0;

  // Free-running 100 MHz clock.
  always #5 clock = ~clock;

  frp_seq i_dut (.clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .low_power_i(low_power_i),
    .test_high_voltage_i(test_high_voltage_i), .pump_on_o(pump_on_o),
    .array_hv_o(array_hv_o), .prog_mode_o(prog_mode_o),
    .erase_mode_o(erase_mode_o), .mass_mode_o(mass_mode_o),
    .array_we_o(array_we_o), .array_addr_o(array_addr_o),
    .array_data_o(array_data_o));

  // Counts byte-program pulses and keeps the last address and data.
  always @(posedge clock) begin
    if (array_we_o === 1'b1) begin
      we_cnt++;
      we_addr = array_addr_o;
      we_data = array_data_o;
    end
  end

  // Protection expected for a row under a given boundary byte.
  function automatic logic exp_prot(logic [15:0] adr, logic [7:0] b);
    if (b === frp_pkg::BOUND_OPEN) return 1'b0;
    return adr >= {frp_pkg::PROT_TOP_BITS, b, 6'h00};
  endfunction : exp_prot

  task automatic final_report();
    $display("checks %0d, errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got,
               exp);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask : wt

  // One classic Wishbone cycle; read data lands in rd.
  task automatic bus(input logic we, input logic [7:0] adr,
                     input logic [31:0] dat);
    int n = 0;
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel_v;
    wb_dat_i <= dat;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 100);
    if (n >= 100) chk(32'h0, 32'h1, "bus answer missing");
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : bus

  // Select a mode, optionally read the boundary, latch a row, ask for HV.
  task automatic hv_try(input logic [3:0] sel, input logic [15:0] adr,
                        input logic ok, input logic rdb);
    bus(1'b1, frp_pkg::OFF_CTRL, {28'h0, sel});
    if (rdb) bus(1'b0, frp_pkg::OFF_BOUND, 32'h0);
    bus(1'b1, frp_pkg::OFF_ARRAY, {8'h00, 8'h5A, adr[15:5], 5'h13});
    wt(1000);
    bus(1'b1, frp_pkg::OFF_CTRL, {28'h0, sel | 4'h8});
    bus(1'b0, frp_pkg::OFF_CTRL, 32'h0);
    chk(rd[frp_pkg::HV_BIT], ok, "hv bit");
    chk(pump_on_o, ok, "pump");
    chk(array_hv_o, ok, "array hv");
    wt(500);
  endtask : hv_try

  // Clears the select, holds, then drops high voltage.
  task automatic hv_off();
    bus(1'b1, frp_pkg::OFF_CTRL, 32'h8);
    wt(500);
    bus(1'b1, frp_pkg::OFF_CTRL, 32'h0);
    chk(pump_on_o, 1'b0, "pump off");
    wt(100);
  endtask : hv_off

  // Full row program with one byte inside the row and one outside it.
  task automatic prog(input logic [15:0] adr, input logic [7:0] d,
                      input logic ok);
    int c;
    hv_try(4'h1, adr, ok, 1'b1);
    c = we_cnt;
    bus(1'b1, frp_pkg::OFF_ARRAY, {8'h00, d, adr});
    wt(3000);
    chk(we_cnt - c, ok, "byte pulse");
    if (ok) chk(we_addr, adr, "byte address");
    if (ok) chk(we_data, d, "byte data");
    bus(1'b1, frp_pkg::OFF_ARRAY, {8'h00, d, adr ^ 16'h0020});
    wt(3000);
    chk(we_cnt - c, ok, "byte outside row");
    hv_off();
  endtask : prog

  // Watchdog set about a quarter above the expected run length.
  initial begin
    #1_000_000;
    err_total++;
    $display("unexpected at %0t: run did not finish", $time);
    final_report();
  end

  // Main sequence.
  initial begin
    void'($urandom(3237));
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    wt(3);
    chk(pump_on_o, 1'b0, "pump at reset");
    bus(1'b0, frp_pkg::OFF_BOUND, 32'h0);
    chk(rd[7:0], frp_pkg::BOUND_RESET, "boundary reset");
    bnd = frp_pkg::BOUND_RESET;
    a = {2'b11, 14'($urandom_range(14'h3DFF))};
    prog(a, 8'($urandom), 1'b1);
    bus(1'b1, frp_pkg::OFF_BOUND, 32'h0000_0000);
    bus(1'b0, frp_pkg::OFF_BOUND, 32'h0);
    chk(rd[7:0], bnd, "boundary bus write");
    bus(1'b1, frp_pkg::OFF_CTRL, 32'h1);
    bus(1'b1, frp_pkg::OFF_CTRL, 32'h3);
    chk({prog_mode_o, erase_mode_o}, 2'b10, "interlock");
    bus(1'b1, frp_pkg::OFF_CTRL, 32'h0);
    sel_v = 4'hE;
    bus(1'b1, frp_pkg::OFF_CTRL, 32'h1);
    sel_v = 4'hF;
    chk(prog_mode_o, 1'b0, "ctrl without byte enable");
    hv_try(4'h1, 16'hC000, 1'b0, 1'b0);
    bus(1'b0, frp_pkg::OFF_STAT, 32'h0);
    chk(rd[frp_pkg::ST_SEQERR_BIT], 1'b1, "sequence error");
    bus(1'b1, frp_pkg::OFF_STAT, 32'h1);
    bus(1'b0, frp_pkg::OFF_STAT, 32'h0);
    chk(rd[frp_pkg::ST_SEQERR_BIT], 1'b0, "sequence error clear");
    hv_off();
    hv_try(4'h6, 16'hC000, 1'b1, 1'b1);
    chk(mass_mode_o, 1'b1, "mass mode");
    hv_off();
    bus(1'b0, frp_pkg::OFF_BOUND, 32'h0);
    chk(rd[7:0], frp_pkg::BOUND_OPEN, "boundary after mass");
    prog(frp_pkg::BOUND_ADDR, 8'h80, 1'b1);
    bnd = 8'h80;
    bus(1'b0, frp_pkg::OFF_BOUND, 32'h0);
    chk(rd[7:0], bnd, "boundary programmed");
    hv_try(4'h6, 16'hC000, 1'b0, 1'b1);
    hv_off();
    hv_try(4'h2, 16'hE000, 1'b0, 1'b1);
    hv_off();
    // Page erase armed, then mass asked together with high voltage.
    bus(1'b1, frp_pkg::OFF_CTRL, 32'h2);
    bus(1'b0, frp_pkg::OFF_BOUND, 32'h0);
    bus(1'b1, frp_pkg::OFF_ARRAY, 32'h0000_C000);
    wt(1000);
    bus(1'b1, frp_pkg::OFF_CTRL, 32'hE);
    bus(1'b0, frp_pkg::OFF_CTRL, 32'h0);
    chk(rd[frp_pkg::HV_BIT], 1'b0, "late mass select");
    hv_off();
    for (int i = 0; i < 4; i++) begin
      a = {2'b11, 14'($urandom_range(14'h3DFF))};
      if (i == 0) a = 16'hDFFF;
      if (i == 1) a = 16'hE000;
      prog(a, 8'($urandom), !exp_prot(a, bnd));
    end
    prog(frp_pkg::BOUND_ADDR, 8'h7F, 1'b0);
    test_high_voltage_i <= 1'b1;
    wt(5);
    bus(1'b0, frp_pkg::OFF_STAT, 32'h0);
    chk(rd[frp_pkg::ST_TESTHV_BIT], 1'b1, "test voltage seen");
    // The boundary page is erased first so that only erased bytes program.
    hv_try(4'h2, frp_pkg::BOUND_ADDR, 1'b1, 1'b1);
    hv_off();
    bus(1'b0, frp_pkg::OFF_BOUND, 32'h0);
    chk(rd[7:0], frp_pkg::BOUND_OPEN, "boundary page erase");
    prog(frp_pkg::BOUND_ADDR, 8'h00, 1'b1);
    bnd = 8'h00;
    test_high_voltage_i <= 1'b0;
    wt(5);
    hv_try(4'h1, 16'hC000, 1'b0, 1'b1);
    hv_off();
    test_high_voltage_i <= 1'b1;
    wt(5);
    hv_try(4'h1, 16'hC000, 1'b1, 1'b1);
    low_power_i <= 1'b1;
    wt(2);
    chk({pump_on_o, prog_mode_o}, 2'b00, "standby");
    low_power_i <= 1'b0;
    bus(1'b0, frp_pkg::OFF_CTRL, 32'h0);
    chk(rd[3:0], 4'h0, "ctrl after abort");
    test_high_voltage_i <= 1'b0;
    final_report();
  end
endmodule : testbench
`default_nettype wire
